// ---- rtl/sgm_regs.svh ----
`ifndef SGM_REGS_SVH
`define SGM_REGS_SVH
// register byte addresses
`define SGM_TIS_ADDR 20'hf_0074
`define SGM_AGC_ADDR 20'hf_0078
`define SGM_PRS_ADDR 20'hf_007b
`define SGM_ADR_ADDR 20'hf_061e
// access_guard_control fields
`define SGM_AGC_DET 7
`define SGM_AGC_RAM_HI 5
`define SGM_AGC_RAM_LO 4
`define SGM_AGC_PORT 2
`define SGM_AGC_IRQ 1
`define SGM_AGC_CLK 0
`define SGM_AGC_WMASK 8'h37
// port_readback_select field
`define SGM_PRS_PIN 0
// ram guard sizes in bytes
`define SGM_RAM_SZ_128 20'h0_0080
`define SGM_RAM_SZ_256 20'h0_0100
`define SGM_RAM_SZ_512 20'h0_0200
// reset values
`define SGM_RST_8 8'h00
`define SGM_RST_16 16'h0000
`endif

// ---- rtl/sgm_pkg.sv ----
package sgm_pkg;
  typedef logic [19:0] sgm_addr_t;
  typedef enum logic [1:0] {
    SGM_RAM_OFF = 2'h0,
    SGM_RAM_128 = 2'h1,
    SGM_RAM_256 = 2'h2,
    SGM_RAM_512 = 2'h3
  } sgm_ram_size_t;
  typedef enum logic [2:0] {
    SGM_CH5_PIN_A = 3'h0,
    SGM_CH5_EVENT = 3'h1,
    SGM_CH5_PIN_B = 3'h2,
    SGM_CH5_MID = 3'h3,
    SGM_CH5_LOW = 3'h4,
    SGM_CH5_SUB = 3'h5
  } sgm_ch5_src_t;
  typedef enum logic [1:0] {
    SGM_DIAG_NONE = 2'h0,
    SGM_DIAG_ZERO = 2'h1,
    SGM_DIAG_HALF = 2'h2,
    SGM_DIAG_FULL = 2'h3
  } sgm_diag_t;
endpackage

// ---- rtl/sgm_rb_if.sv ----
`timescale 1ns/10ps
interface sgm_rb_if;
  logic [7:0] port_latch;
  logic [7:0] pin_level;
  logic [7:0] port_direction_reg;
  logic [7:0] seg_active;
  logic i2c_unit_enable;
  logic pin_level_readback;
  logic [7:0] result;
  modport top (
    output port_latch,
    output pin_level,
    output port_direction_reg,
    output seg_active,
    output i2c_unit_enable,
    output pin_level_readback,
    input result
  );
  modport rb (
    input port_latch,
    input pin_level,
    input port_direction_reg,
    input seg_active,
    input i2c_unit_enable,
    input pin_level_readback,
    output result
  );
endinterface

// ---- rtl/sgm_readback.sv ----
`timescale 1ns/10ps
module sgm_readback #(
  parameter logic [7:0] LCD_ONLY_MASK = 8'h00,
  parameter logic [7:0] INPUT_ONLY_MASK = 8'h00,
  parameter logic [7:0] I2C_PIN_MASK = 8'h03
) (
  sgm_rb_if.rb rb
);
  genvar i;
  generate
    for (i = 0; i < 8; i++)
    begin : g_pin
      logic exempt;
      // dedicated lcd, input-only and idle i2c pins keep plain behaviour
      assign exempt = LCD_ONLY_MASK[i] | INPUT_ONLY_MASK[i]
                    | (I2C_PIN_MASK[i] & ~rb.i2c_unit_enable);
      always_comb
      begin
        if (rb.port_direction_reg[i])
          rb.result[i] = rb.pin_level[i];
        else if (!rb.pin_level_readback || exempt)
          rb.result[i] = rb.port_latch[i];
        else if (rb.seg_active[i])
          rb.result[i] = 1'b0;
        else
          rb.result[i] = rb.pin_level[i];
      end
    end
  endgenerate
endmodule // sgm_readback

// ---- rtl/sgm_guard.sv ----
`timescale 1ns/10ps
`include "sgm_regs.svh"
module sgm_guard
  import sgm_pkg::*;
#(
  parameter sgm_addr_t RAM_START = 20'hf_3f00,
  parameter int NUM_BAD = 2,
  parameter logic [NUM_BAD*20-1:0] BAD_LO = {20'hf_0800, 20'h8_0000},
  parameter logic [NUM_BAD*20-1:0] BAD_HI = {20'hf_0fff, 20'he_ffff},
  parameter sgm_addr_t PORT_CFG_LO = 20'hf_0020,
  parameter sgm_addr_t PORT_CFG_HI = 20'hf_006f,
  parameter sgm_addr_t PORT_DATA_LO = 20'hf_ff00,
  parameter sgm_addr_t PORT_DATA_HI = 20'hf_ff1f,
  parameter sgm_addr_t PORT_RB_ADDR = 20'hf_ff00,
  parameter sgm_addr_t IRQ_CFG_LO = 20'hf_ffd0,
  parameter sgm_addr_t IRQ_CFG_HI = 20'hf_ffef,
  parameter sgm_addr_t CLK_CFG_LO = 20'hf_00a0,
  parameter sgm_addr_t CLK_CFG_HI = 20'hf_00ff,
  parameter logic [7:0] LCD_ONLY_MASK = 8'h00,
  parameter logic [7:0] INPUT_ONLY_MASK = 8'h00,
  parameter logic [7:0] I2C_PIN_MASK = 8'h03
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire sgm_addr_t cpu_addr,
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  input wire logic cpu_fetch,
  input wire logic [15:0] cpu_wdata,
  output logic [15:0] cpu_rdata,
  output logic fwd_wr,
  output sgm_addr_t fwd_addr,
  output logic [15:0] fwd_wdata,
  output logic wr_blocked,
  output logic bad_access_reset,
  input wire logic watchdog_run_option,
  input wire logic timer_ch5_input_pin,
  input wire logic event_link_in,
  input wire logic mid_osc_clk,
  input wire logic low_osc_clk,
  input wire logic sub_clk,
  output logic ch5_ref_out,
  input wire logic adc_diag_valid,
  input wire logic [11:0] adc_diag_value,
  input wire logic [1:0] adc_diag_status,
  input wire logic adc_accum_mode,
  input wire logic adc_alignment_select,
  input wire logic [7:0] port_latch,
  input wire logic [7:0] port_pin_level,
  input wire logic [7:0] port_direction_reg,
  input wire logic [7:0] seg_active,
  input wire logic i2c_unit_enable
);
  logic [7:0] timer_input_select;
  logic [7:0] access_guard_control;
  logic [7:0] port_readback_select;
  logic [15:0] adc_selfcheck_result;
  logic [7:0] pin_meta, pin_sync;
  logic [3:0] clk_meta, clk_sync;
  logic hit_tis, hit_agc, hit_prs, hit_adr, hit_own;
  logic in_ram, in_port_cfg, in_port_data, in_irq, in_clk, in_bad;
  logic guard_hit, detect_on;
  sgm_addr_t ram_size;
  sgm_ram_size_t ram_sel;
  sgm_ch5_src_t ch5_sel;
  logic next_ch5;
  logic [15:0] next_rdata;
  sgm_rb_if rbi();

  assign hit_tis = cpu_addr == `SGM_TIS_ADDR;
  assign hit_agc = cpu_addr == `SGM_AGC_ADDR;
  assign hit_prs = cpu_addr == `SGM_PRS_ADDR;
  assign hit_adr = cpu_addr == `SGM_ADR_ADDR;
  assign hit_own = hit_tis | hit_agc | hit_prs | hit_adr;

  assign ram_sel = sgm_ram_size_t'(access_guard_control[`SGM_AGC_RAM_HI:`SGM_AGC_RAM_LO]);
  always_comb
  begin
    unique case (ram_sel)
      SGM_RAM_OFF: ram_size = 20'h0_0000;
      SGM_RAM_128: ram_size = `SGM_RAM_SZ_128;
      SGM_RAM_256: ram_size = `SGM_RAM_SZ_256;
      SGM_RAM_512: ram_size = `SGM_RAM_SZ_512;
    endcase
  end
  assign in_ram = cpu_addr >= RAM_START && (cpu_addr - RAM_START) < ram_size;
  assign in_port_data = cpu_addr >= PORT_DATA_LO && cpu_addr <= PORT_DATA_HI;
  // data latches excluded from the port guard
  assign in_port_cfg = cpu_addr >= PORT_CFG_LO && cpu_addr <= PORT_CFG_HI && !in_port_data;
  assign in_irq = cpu_addr >= IRQ_CFG_LO && cpu_addr <= IRQ_CFG_HI;
  assign in_clk = cpu_addr >= CLK_CFG_LO && cpu_addr <= CLK_CFG_HI;
  assign guard_hit = in_ram
    | (in_port_cfg & access_guard_control[`SGM_AGC_PORT])
    | (in_irq & access_guard_control[`SGM_AGC_IRQ])
    | (in_clk & access_guard_control[`SGM_AGC_CLK]);

  // prohibited ranges from parameters
  always_comb
  begin
    in_bad = 1'b0;
    for (int k = 0; k < NUM_BAD; k++)
    begin
      if (cpu_addr >= BAD_LO[k*20 +: 20] && cpu_addr <= BAD_HI[k*20 +: 20])
        in_bad = 1'b1;
    end
  end
  assign detect_on = access_guard_control[`SGM_AGC_DET] | watchdog_run_option;

  // pin and foreign-clock synchronisers
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      pin_meta <= `SGM_RST_8;
      pin_sync <= `SGM_RST_8;
      clk_meta <= 4'h0;
      clk_sync <= 4'h0;
    end
    else if (clk_en)
    begin
      pin_meta <= port_pin_level;
      pin_sync <= pin_meta;
      clk_meta <= {sub_clk, low_osc_clk, mid_osc_clk, timer_ch5_input_pin};
      clk_sync <= clk_meta;
    end
  end

  // guard control: set-only detect bit, reset to zero
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      access_guard_control <= `SGM_RST_8;
    else if (clk_en && cpu_wr && hit_agc)
    begin
      access_guard_control <= (cpu_wdata[7:0] & `SGM_AGC_WMASK)
        | {access_guard_control[`SGM_AGC_DET] | cpu_wdata[`SGM_AGC_DET], 7'h00};
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      timer_input_select <= `SGM_RST_8;
    else if (clk_en && cpu_wr && hit_tis)
      timer_input_select <= cpu_wdata[7:0];
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      port_readback_select <= `SGM_RST_8;
    else if (clk_en && cpu_wr && hit_prs)
      port_readback_select <= {7'h00, cpu_wdata[`SGM_PRS_PIN]};
  end

  // diagnosis result, kept right-aligned internally
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      adc_selfcheck_result <= `SGM_RST_16;
    else if (clk_en && adc_diag_valid && !adc_accum_mode)
      adc_selfcheck_result <= {adc_diag_status, 2'h0, adc_diag_value};
  end

  // write forwarding; blocked writes finish silently
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      fwd_wr <= 1'b0;
      fwd_addr <= 20'h0_0000;
      fwd_wdata <= `SGM_RST_16;
      wr_blocked <= 1'b0;
    end
    else if (clk_en)
    begin
      fwd_wr <= cpu_wr && !hit_own && !guard_hit;
      wr_blocked <= cpu_wr && !hit_own && guard_hit;
      fwd_addr <= cpu_addr;
      fwd_wdata <= cpu_wdata;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      bad_access_reset <= 1'b0;
    else if (clk_en)
      bad_access_reset <= detect_on && in_bad && (cpu_rd | cpu_wr | cpu_fetch);
  end

  // channel 5 reference source
  assign ch5_sel = sgm_ch5_src_t'(timer_input_select[2:0]);
  always_comb
  begin
    case (ch5_sel)
      SGM_CH5_PIN_A, SGM_CH5_PIN_B: next_ch5 = clk_sync[0];
      SGM_CH5_EVENT: next_ch5 = event_link_in;
      SGM_CH5_MID: next_ch5 = clk_sync[1];
      SGM_CH5_LOW: next_ch5 = clk_sync[2];
      SGM_CH5_SUB: next_ch5 = clk_sync[3];
      default: next_ch5 = 1'b0;
    endcase
  end
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      ch5_ref_out <= 1'b0;
    else if (clk_en)
      ch5_ref_out <= next_ch5;
  end

  // port readback
  assign rbi.port_latch = port_latch;
  assign rbi.pin_level = pin_sync;
  assign rbi.port_direction_reg = port_direction_reg;
  assign rbi.seg_active = seg_active;
  assign rbi.i2c_unit_enable = i2c_unit_enable;
  assign rbi.pin_level_readback = port_readback_select[`SGM_PRS_PIN];
  sgm_readback #(
    .LCD_ONLY_MASK(LCD_ONLY_MASK),
    .INPUT_ONLY_MASK(INPUT_ONLY_MASK),
    .I2C_PIN_MASK(I2C_PIN_MASK)
  ) u_sgm_readback (
    .rb(rbi.rb)
  );

  // read data mux
  always_comb
  begin
    next_rdata = `SGM_RST_16;
    if (hit_tis)
      next_rdata = {8'h00, timer_input_select};
    else if (hit_agc)
      next_rdata = {8'h00, access_guard_control};
    else if (hit_prs)
      next_rdata = {8'h00, port_readback_select};
    else if (hit_adr && adc_alignment_select)
      next_rdata = {adc_selfcheck_result[11:0], 2'h0,
                    adc_selfcheck_result[15:14]};
    else if (hit_adr)
      next_rdata = adc_selfcheck_result;
    else if (cpu_addr == PORT_RB_ADDR)
      next_rdata = {8'h00, rbi.result};
  end
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      cpu_rdata <= `SGM_RST_16;
    else if (clk_en && cpu_rd)
      cpu_rdata <= next_rdata;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_wr_ram;
    clk_en && cpu_wr && in_ram && !hit_own;
  endsequence
  sequence s_quiet_block;
    !fwd_wr && wr_blocked;
  endsequence

  AST_RAM_BLOCK: assert property (s_wr_ram |=> s_quiet_block)
    else $error("ram guard let a write through");
  AST_RAM_SIZE: assert property (clk_en && cpu_wr && !hit_own
      && !in_port_cfg && !in_irq && !in_clk && cpu_addr == RAM_START + 20'h0_0080
      && ram_sel == SGM_RAM_128 |=> fwd_wr)
    else $error("128-byte guard blocked byte 128");
  AST_PORT_GUARD: assert property (clk_en && cpu_wr && in_port_cfg
      && access_guard_control[`SGM_AGC_PORT] |=> s_quiet_block)
    else $error("port configuration write passed guard");
  AST_PORT_DATA: assert property (clk_en && cpu_wr && in_port_data
      && !in_ram && !in_irq && !in_clk && !hit_own |=> fwd_wr && !wr_blocked)
    else $error("port data write was blocked");
  AST_IRQ_GUARD: assert property (clk_en && cpu_wr && in_irq
      && access_guard_control[`SGM_AGC_IRQ] |=> !fwd_wr)
    else $error("interrupt register write passed guard");
  AST_CLK_GUARD: assert property (clk_en && cpu_wr && in_clk
      && access_guard_control[`SGM_AGC_CLK] |=> !fwd_wr)
    else $error("clock register write passed guard");
  AST_DET_STICKY: assert property (access_guard_control[`SGM_AGC_DET]
      |=> access_guard_control[`SGM_AGC_DET] [*2])
    else $error("detect enable was cleared");
  AST_BAD_RESET: assert property (clk_en && in_bad
      && (cpu_rd | cpu_wr | cpu_fetch)
      && (access_guard_control[`SGM_AGC_DET] | watchdog_run_option)
      |=> bad_access_reset)
    else $error("prohibited access gave no reset");
  AST_NO_FALSE_RESET: assert property (clk_en && !in_bad |=> !bad_access_reset)
    else $error("reset raised for a legal access");
  AST_CH5_PROHIBITED: assert property (clk_en
      && timer_input_select[2:1] == 2'h3 |=> !ch5_ref_out)
    else $error("prohibited channel-5 code drove a clock");
  AST_ADR_RIGHT: assert property (clk_en && cpu_rd && hit_adr
      && !adc_alignment_select
      |=> cpu_rdata[13:12] == 2'h0 && cpu_rdata[11:0] == $past(adc_selfcheck_result[11:0]))
    else $error("right-aligned diagnosis read wrong");
  AST_ADR_LEFT: assert property (clk_en && cpu_rd && hit_adr
      && adc_alignment_select
      |=> cpu_rdata[3:2] == 2'h0 && cpu_rdata[1:0] == $past(adc_selfcheck_result[15:14]))
    else $error("left-aligned diagnosis read wrong");
  AST_ADR_HOLD: assert property (clk_en && adc_diag_valid && adc_accum_mode
      |=> $stable(adc_selfcheck_result))
    else $error("accumulated result reached diagnosis register");

  // own registers stay off the forwarded bus
  sequence s_own_wr;
    clk_en && cpu_wr && hit_own;
  endsequence
  AST_OWN_QUIET: assert property (s_own_wr |=> !fwd_wr && !wr_blocked)
    else $error("own register write reached the bus");
  AST_ADR_RO: assert property (clk_en && cpu_wr && hit_adr && !adc_diag_valid
      |=> $stable(adc_selfcheck_result))
    else $error("diagnosis result changed on a bus write");
  AST_DET_SET: assert property (clk_en && cpu_wr && hit_agc && cpu_wdata[`SGM_AGC_DET]
      |=> access_guard_control[`SGM_AGC_DET])
    else $error("detect enable did not set");
endmodule // sgm_guard

// ---- verif/sgm_cpu_model.sv ----
`timescale 1ns/10ps
module sgm_cpu_model
  import sgm_pkg::*;
(
  input wire logic ref_clk,
  output sgm_addr_t cpu_addr,
  output logic cpu_rd,
  output logic cpu_wr,
  output logic cpu_fetch,
  output logic [15:0] cpu_wdata,
  input wire logic [15:0] cpu_rdata,
  input wire logic fwd_wr,
  input wire logic wr_blocked,
  input wire logic bad_access_reset
);
  logic [15:0] rdata_q;
  logic fwd_q, blk_q, bad_q;
  initial
  begin
    {cpu_addr, cpu_rd, cpu_wr, cpu_fetch, cpu_wdata} = '0;
  end
  // kind 0 read, 1 write, 2 fetch; writes always carry a whole word
  task automatic acc(input int k, input sgm_addr_t a, input logic [15:0] d);
    @(posedge ref_clk);
    #1;
    cpu_addr = a;
    cpu_wdata = d;
    cpu_rd = (k == 0);
    cpu_wr = (k == 1);
    cpu_fetch = (k == 2);
    @(posedge ref_clk);
    #1;
    rdata_q = cpu_rdata;
    fwd_q = fwd_wr;
    blk_q = wr_blocked;
    bad_q = bad_access_reset;
    {cpu_rd, cpu_wr, cpu_fetch} = '0;
    // released bus shows the inverse, not a stale copy
    cpu_addr = ~a;
    cpu_wdata = ~d;
  endtask
endmodule // sgm_cpu_model

// ---- verif/tb_safety_guard_monitor.sv ----
`timescale 1ns/10ps
`include "sgm_regs.svh"
module tb_safety_guard_monitor
  import sgm_pkg::*;
;
  localparam sgm_addr_t RAMS = 20'hf_3f00;
  localparam logic [7:0] LCDM = 8'h40;
  localparam logic [7:0] INPM = 8'h80;
  localparam logic [7:0] I2CM = 8'h03;
  logic ref_clk, reset_n, clk_en, cpu_rd, cpu_wr, cpu_fetch, fwd_wr, wr_blocked;
  logic bad_access_reset, watchdog_run_option, timer_ch5_input_pin, event_link_in;
  logic mid_osc_clk, low_osc_clk, sub_clk, ch5_ref_out, adc_diag_valid;
  logic adc_accum_mode, adc_alignment_select, i2c_unit_enable;
  sgm_addr_t cpu_addr, fwd_addr;
  logic [15:0] cpu_wdata, cpu_rdata, fwd_wdata, pe;
  logic [11:0] adc_diag_value, ev;
  logic [1:0] adc_diag_status, es;
  logic [7:0] port_latch, port_pin_level, port_direction_reg, seg_active;
  int mismatches, samples_checked, cyc, sz;
  int seed = 32'h56b0_c067;
  sgm_addr_t ra[4] = '{`SGM_TIS_ADDR, `SGM_AGC_ADDR, `SGM_PRS_ADDR, `SGM_ADR_ADDR};
  sgm_addr_t ga[3] = '{20'hf_0020, 20'hf_ffd0, 20'hf_00f5};
  logic [7:0] gb[3] = '{8'h04, 8'h02, 8'h01};

  sgm_guard #(.RAM_START(RAMS), .LCD_ONLY_MASK(LCDM), .INPUT_ONLY_MASK(INPM),
    .I2C_PIN_MASK(I2CM)) u_sgm_guard (.ref_clk, .reset_n, .clk_en, .cpu_addr, .cpu_rd,
    .cpu_wr, .cpu_fetch, .cpu_wdata, .cpu_rdata, .fwd_wr, .fwd_addr, .fwd_wdata,
    .wr_blocked, .bad_access_reset, .watchdog_run_option, .timer_ch5_input_pin,
    .event_link_in, .mid_osc_clk, .low_osc_clk, .sub_clk, .ch5_ref_out, .adc_diag_valid,
    .adc_diag_value, .adc_diag_status, .adc_accum_mode, .adc_alignment_select,
    .port_latch, .port_pin_level, .port_direction_reg, .seg_active, .i2c_unit_enable);
  sgm_cpu_model u_sgm_cpu_model (.ref_clk, .cpu_addr, .cpu_rd, .cpu_wr, .cpu_fetch,
    .cpu_wdata, .cpu_rdata, .fwd_wr, .wr_blocked, .bad_access_reset);

  initial
  begin
    ref_clk = 0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input string n, input sgm_addr_t a, input logic [15:0] e);
    u_sgm_cpu_model.acc(0, a, 16'h0000);
    chk(n, e, u_sgm_cpu_model.rdata_q);
  endtask
  task automatic wchk(input sgm_addr_t a, input logic b);
    logic [15:0] d;
    d = 16'($random(seed));
    u_sgm_cpu_model.acc(1, a, d);
    chk("blocked", 16'(b), 16'(u_sgm_cpu_model.blk_q));
    chk("forwarded", 16'(!b), 16'(u_sgm_cpu_model.fwd_q));
    chk("fwd_addr", a, fwd_addr);
    chk("fwd_wdata", d, fwd_wdata);
  endtask
  task automatic bchk(input int k, input sgm_addr_t a, input logic b);
    u_sgm_cpu_model.acc(k, a, 16'h0000);
    chk("bad_reset", 16'(b), 16'(u_sgm_cpu_model.bad_q));
  endtask
  task automatic wr(input sgm_addr_t a, input logic [7:0] d);
    u_sgm_cpu_model.acc(1, a, {8'h00, d});
  endtask
  task automatic do_reset();
    @(posedge ref_clk);
    #1;
    reset_n = 0;
    repeat (16) @(posedge ref_clk);
    #1;
    reset_n = 1;
  endtask

  function automatic logic ch5_exp(int c);
    case (c)
      0, 2: return timer_ch5_input_pin;
      1: return event_link_in;
      3: return mid_osc_clk;
      4: return low_osc_clk;
      5: return sub_clk;
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic [7:0] rb_exp(logic sel);
    logic [7:0] x;
    logic [7:0] r;
    x = LCDM | INPM | (I2CM & {8{!i2c_unit_enable}});
    for (int i = 0; i < 8; i++)
      r[i] = port_direction_reg[i] ? port_pin_level[i] :
        (!sel || x[i]) ? port_latch[i] : !seg_active[i] && port_pin_level[i];
    return r;
  endfunction

  initial
  begin
    clk_en = 1;
    {reset_n, watchdog_run_option, timer_ch5_input_pin, event_link_in, mid_osc_clk,
      low_osc_clk, sub_clk, adc_diag_valid, adc_accum_mode, adc_alignment_select} = '0;
    {i2c_unit_enable, port_latch, port_pin_level, port_direction_reg, seg_active} = '0;
    {adc_diag_value, adc_diag_status} = '0;
    do_reset();
    foreach (ra[i]) rchk("reset_value", ra[i], 16'h0000);
    for (int c = 0; c < 4; c++)
    begin
      sz = (c == 0) ? 0 : 64 << c;
      wr(`SGM_AGC_ADDR, 8'(c << 4));
      rchk("guard_ctl", `SGM_AGC_ADDR, 16'(c << 4));
      if (c != 0) wchk(RAMS + 20'(sz - 1), 1);
      wchk(RAMS + 20'(sz), 0);
      wchk(RAMS - 20'h0_0001, 0);
    end
    foreach (ga[g])
    begin
      wr(`SGM_AGC_ADDR, gb[g]);
      foreach (ga[h]) wchk(ga[h], g == h);
      wchk(20'hf_ff00, 0);
    end
    wr(`SGM_AGC_ADDR, 8'h00);
    for (int c = 0; c < 8; c++)
    begin
      wr(`SGM_TIS_ADDR, 8'(c));
      repeat (3)
      begin
        {timer_ch5_input_pin, event_link_in, mid_osc_clk, low_osc_clk, sub_clk} =
          5'($random(seed));
        repeat (5) @(posedge ref_clk);
        #1;
        chk("ch5_ref", 16'(ch5_exp(c)), 16'(ch5_ref_out));
      end
    end
    for (int n = 0; n < 24; n++)
    begin
      {port_latch, port_pin_level, port_direction_reg} = 24'($random(seed));
      {seg_active, i2c_unit_enable} = 9'($random(seed));
      wr(`SGM_PRS_ADDR, 8'(n & 1));
      rchk("readback_sel", `SGM_PRS_ADDR, 16'(n & 1));
      pe = {8'h00, rb_exp(n[0])};
      rchk("port_read", 20'hf_ff00, pe);
    end
    for (int s = 0; s < 5; s++)
    begin
      @(posedge ref_clk);
      #1;
      adc_accum_mode = (s == 4);
      adc_diag_value = 12'($random(seed));
      adc_diag_status = 2'(s);
      adc_diag_valid = 1;
      @(posedge ref_clk);
      #1;
      adc_diag_valid = 0;
      if (s < 4) ev = adc_diag_value;
      if (s < 4) es = 2'(s);
      for (int a = 0; a < 2; a++)
      begin
        adc_alignment_select = a[0];
        pe = a ? {ev, 2'b00, es} : {es, 2'b00, ev};
        rchk("diag", `SGM_ADR_ADDR, pe);
      end
    end
    u_sgm_cpu_model.acc(1, `SGM_ADR_ADDR, 16'hffff);
    rchk("diag_ro", `SGM_ADR_ADDR, {ev, 2'b00, es});
    bchk(2, 20'hf_0800, 0);
    wr(`SGM_AGC_ADDR, 8'h80);
    wr(`SGM_AGC_ADDR, 8'h00);
    rchk("detect_sticky", `SGM_AGC_ADDR, 16'h0080);
    bchk(2, 20'hf_0fff, 1);
    bchk(0, 20'h8_0000, 1);
    bchk(1, 20'h7_ffff, 0);
    do_reset();
    rchk("ctl_after_reset", `SGM_AGC_ADDR, 16'h0000);
    bchk(2, 20'hf_0800, 0);
    watchdog_run_option = 1;
    bchk(2, 20'he_ffff, 1);
    rchk("ctl_with_option", `SGM_AGC_ADDR, 16'h0000);
    // clock enable low: the write must not land
    clk_en = 0;
    u_sgm_cpu_model.acc(1, `SGM_TIS_ADDR, 16'h0005);
    clk_en = 1;
    rchk("frozen_tis", `SGM_TIS_ADDR, 16'h0000);
    wrap_up();
  end
endmodule // tb_safety_guard_monitor
